// file: include/rst_mii_pkg.sv
// constants for the reset and MII port select block
package rst_mii_pkg;
  localparam int CLK_MHZ = 200;
  localparam int POR_MS = 22;
  localparam int SOFT_RST_US = 2;
  localparam int PHY_RST_US = 100;
  localparam int WAKE_MS = 2;
  localparam int EEPROM_PROBE_CYC = 64;
  localparam int POR_CYC = POR_MS * 1000 * CLK_MHZ;
  localparam int SOFT_RST_CYC = SOFT_RST_US * CLK_MHZ;
  localparam int PHY_RST_CYC = PHY_RST_US * CLK_MHZ;
  localparam int WAKE_CYC = WAKE_MS * 1000 * CLK_MHZ;
  localparam int SOFT_RST_BIT = 0;
  localparam int PHY_RST_BIT = 10;
  localparam int PHY_CTL_RST_BIT = 15;
  localparam int EEPROM_BUSY_BIT = 31;
  localparam logic [1:0] CLK_SEL_INT = 2'h0;
  localparam logic [1:0] CLK_SEL_EXT = 2'h1;
  localparam logic [1:0] CLK_SEL_OFF = 2'h2;
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam int CNT_W = 24;
endpackage : rst_mii_pkg

// file: hw/pulse_timer.sv
// one-shot cycle timer: busy from start until count expires
`timescale 1ns/100ps
module pulse_timer
  import rst_mii_pkg::*;
#(
  parameter int COUNT = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [CNT_W-1:0] cnt_r;
  logic busy_r;
  logic done_r;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        // restart wins so a retrigger extends the pulse
        cnt_r <= CNT_W'(COUNT - 1);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r == '0) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

  assign busy = busy_r | start;
  assign done = done_r;
endmodule : pulse_timer

// file: hw/reset_and_mii_port_select.sv
// reset source arbitration, ready sequencing and MII port switching
`timescale 1ns/100ps
module reset_and_mii_port_select
  import rst_mii_pkg::*;
#(
  parameter int POR_COUNT = POR_CYC,
  parameter int WAKE_COUNT = WAKE_CYC,
  parameter int PROBE_COUNT = EEPROM_PROBE_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // reset pin (pull-up is in the pad)
  input wire logic HW_RESET_PIN_N,
  // host control strobes
  input wire logic SOFT_RESET_WR,
  input wire logic PHY_RESET_WR,
  input wire logic PHY_CTL_RESET_WR,
  input wire logic WAKE_TEST_WR,
  input wire logic EEPROM_DONE,
  // configuration
  input wire logic MII_PORT_SELECT_BIT,
  input wire logic MGMT_PORT_SELECT_BIT,
  input wire logic [1:0] CLK_SRC_SEL,
  // status
  output logic READY,
  output logic SOFT_RESET_BIT,
  output logic PHY_RESET_BIT,
  output logic PHY_CTL_RESET_BIT,
  output logic EEPROM_BUSY_FLAG,
  output logic [1:0] POWER_STATE_FIELD,
  // reset outputs per domain
  output logic PLL_RST,
  output logic HOST_BUS_RST,
  output logic EXEMPT_REG_RST,
  output logic MII_RST,
  output logic MAC_RST,
  output logic PHY_RST,
  output logic STRAP_LATCH,
  output logic MAC_ADDR_RELOAD,
  // MII clock enables for synchronous gating
  output logic INT_MII_CLK_EN,
  output logic EXT_MII_CLK_EN,
  // MII data path, MAC side
  input wire logic [3:0] MAC_TXD,
  input wire logic MAC_TX_EN,
  output logic [3:0] MAC_RXD,
  output logic MAC_RX_DV,
  output logic MAC_RX_ER,
  output logic MAC_CRS,
  output logic MAC_COL,
  // internal PHY
  output logic [3:0] INT_TXD,
  output logic INT_TX_EN,
  input wire logic [3:0] INT_RXD,
  input wire logic INT_RX_DV,
  input wire logic INT_RX_ER,
  input wire logic INT_CRS,
  input wire logic INT_COL,
  input wire logic INT_MDIO_IN,
  output logic INT_MDC,
  output logic INT_MDIO_OUT,
  output logic INT_MDIO_OE,
  // external MII port (pins)
  output logic [3:0] EXT_TXD,
  output logic EXT_TX_EN,
  input wire logic [3:0] EXT_RXD,
  input wire logic EXT_RX_DV,
  input wire logic EXT_RX_ER,
  input wire logic EXT_CRS,
  input wire logic EXT_COL,
  input wire logic EXT_MDIO_IN,
  output logic EXT_MDC,
  output logic EXT_MDIO_OUT,
  output logic EXT_MDIO_OE,
  // SMI master side
  input wire logic SMI_MDC,
  input wire logic SMI_MDIO_OUT,
  input wire logic SMI_MDIO_OE,
  output logic SMI_MDIO_IN
);
  typedef enum logic [2:0] {ST_POR, ST_PIN, ST_SOFT, ST_RUN, ST_WAKE} rst_state_e;
  rst_state_e state_r;
  logic pin_s1_r, pin_s2_r;
  logic por_busy, por_done, soft_busy, soft_done, phy_busy, wake_done;
  logic pin_low;
  logic full_rst;
  logic probe_start_r;
  logic probe_busy, probe_done;
  logic phy_ctl_r;
  logic ready_r;
  logic [1:0] pm_r;
  logic pin_rel_r;

  ////////////////////////////////////////////////////////////////////
  // reset pin synchroniser
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= HW_RESET_PIN_N;
      pin_s2_r <= pin_s1_r;
    end
  end
  assign pin_low = ~pin_s2_r;

  ////////////////////////////////////////////////////////////////////
  // timers
  pulse_timer #(.COUNT(POR_COUNT)) u_por (
    .CLK(CLK), .SYS_RST(1'b0), .start(SYS_RST), .busy(por_busy), .done(por_done));
  pulse_timer #(.COUNT(SOFT_RST_CYC)) u_soft (
    .CLK(CLK), .SYS_RST(full_rst), .start(SOFT_RESET_WR & ~full_rst),
    .busy(soft_busy), .done(soft_done));
  pulse_timer #(.COUNT(PHY_RST_CYC)) u_phy (
    .CLK(CLK), .SYS_RST(full_rst), .start(PHY_RESET_WR & ~full_rst),
    .busy(phy_busy), .done());
  pulse_timer #(.COUNT(WAKE_COUNT)) u_wake (
    .CLK(CLK), .SYS_RST(full_rst), .start(WAKE_TEST_WR & ~full_rst),
    .busy(), .done(wake_done));
  pulse_timer #(.COUNT(PROBE_COUNT)) u_probe (
    .CLK(CLK), .SYS_RST(SYS_RST), .start(probe_start_r),
    .busy(probe_busy), .done(probe_done));

  // power-on reset is seen as SYS_RST plus its timer
  assign full_rst = SYS_RST | por_busy | pin_low;

  ////////////////////////////////////////////////////////////////////
  // reset sequencing and ready flag
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r <= ST_POR;
      ready_r <= 1'b0;
      pm_r <= PM_NORMAL;
    end else if (pin_low) begin
      state_r <= ST_PIN;
      ready_r <= 1'b0;
      pm_r <= PM_NORMAL;
    end else begin
      case (state_r)
        ST_POR: if (!por_busy) begin
          state_r <= ST_RUN;
          ready_r <= 1'b1;
        end
        ST_PIN: begin
          state_r <= ST_RUN;
          ready_r <= 1'b1;
        end
        ST_SOFT: if (soft_done) begin
          state_r <= ST_RUN;
          ready_r <= 1'b1;
        end
        ST_RUN: begin
          if (SOFT_RESET_WR) begin
            state_r <= ST_SOFT;
            ready_r <= 1'b0;
          end else if (WAKE_TEST_WR) begin
            state_r <= ST_WAKE;
            ready_r <= 1'b0;
            pm_r <= PM_NORMAL;
          end
        end
        ST_WAKE: if (wake_done) begin
          state_r <= ST_RUN;
          ready_r <= 1'b1;
        end
        default: state_r <= ST_POR;
      endcase
    end
  end

  // probe begins on the release of any full or soft reset
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      probe_start_r <= 1'b0;
      pin_rel_r <= 1'b0;
    end else begin
      pin_rel_r <= full_rst;
      probe_start_r <= (pin_rel_r & ~full_rst) | soft_done;
    end
  end
  // busy drops at probe timeout or when the loader reports done
  logic ee_busy_r;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ee_busy_r <= 1'b1;
    end else if (full_rst || probe_start_r || soft_busy) begin
      ee_busy_r <= 1'b1;
    end else if (EEPROM_DONE || probe_done) begin
      ee_busy_r <= 1'b0;
    end
  end

  // PHY control reset bit clears on the first cycle the PHY timer is idle; the write does not start that timer
  always_ff @(posedge CLK) begin
    if (full_rst) begin
      phy_ctl_r <= 1'b0;
    end else if (PHY_CTL_RESET_WR) begin
      phy_ctl_r <= 1'b1;
    end else if (!phy_busy) begin
      phy_ctl_r <= 1'b0;
    end
  end
  logic phy_ctl_busy;
  assign phy_ctl_busy = phy_ctl_r | PHY_CTL_RESET_WR;

  ////////////////////////////////////////////////////////////////////
  // per-domain reset fan-out
  logic mii_gate_r;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PLL_RST <= 1'b1;
      HOST_BUS_RST <= 1'b1;
      EXEMPT_REG_RST <= 1'b1;
      MII_RST <= 1'b1;
      MAC_RST <= 1'b1;
      PHY_RST <= 1'b1;
      STRAP_LATCH <= 1'b0;
      MAC_ADDR_RELOAD <= 1'b0;
    end else begin
      PLL_RST <= full_rst;
      EXEMPT_REG_RST <= full_rst;
      HOST_BUS_RST <= full_rst | soft_busy;
      MII_RST <= full_rst | soft_busy;
      MAC_RST <= full_rst | soft_busy;
      PHY_RST <= full_rst | phy_busy | phy_ctl_busy;
      // straps caught after release, never under the reset itself
      STRAP_LATCH <= pin_rel_r & ~full_rst;
      MAC_ADDR_RELOAD <= probe_start_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // MII clock gating: enables feed clock-gate cells, changing only here
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      INT_MII_CLK_EN <= 1'b0;
      EXT_MII_CLK_EN <= 1'b0;
      mii_gate_r <= 1'b1;
    end else begin
      mii_gate_r <= (CLK_SRC_SEL == CLK_SEL_OFF);
      INT_MII_CLK_EN <= (CLK_SRC_SEL == CLK_SEL_INT) && !mii_gate_r;
      EXT_MII_CLK_EN <= (CLK_SRC_SEL == CLK_SEL_EXT) && !mii_gate_r;
    end
  end

  // data and control multiplexer; clocks and SMI are not switched here
  always_comb begin
    INT_TXD = MII_PORT_SELECT_BIT ? 4'h0 : MAC_TXD;
    INT_TX_EN = ~MII_PORT_SELECT_BIT & MAC_TX_EN;
    EXT_TXD = MII_PORT_SELECT_BIT ? MAC_TXD : 4'h0;
    EXT_TX_EN = MII_PORT_SELECT_BIT & MAC_TX_EN;
    MAC_RXD = MII_PORT_SELECT_BIT ? EXT_RXD : INT_RXD;
    MAC_RX_DV = MII_PORT_SELECT_BIT ? EXT_RX_DV : INT_RX_DV;
    MAC_RX_ER = MII_PORT_SELECT_BIT ? EXT_RX_ER : INT_RX_ER;
    MAC_CRS = MII_PORT_SELECT_BIT ? EXT_CRS : INT_CRS;
    MAC_COL = MII_PORT_SELECT_BIT ? EXT_COL : INT_COL;
  end

  // SMI routing on its own select
  always_comb begin
    INT_MDC = MGMT_PORT_SELECT_BIT ? 1'b0 : SMI_MDC;
    INT_MDIO_OUT = SMI_MDIO_OUT;
    INT_MDIO_OE = ~MGMT_PORT_SELECT_BIT & SMI_MDIO_OE;
    EXT_MDC = MGMT_PORT_SELECT_BIT ? SMI_MDC : 1'b0;
    EXT_MDIO_OUT = SMI_MDIO_OUT;
    EXT_MDIO_OE = MGMT_PORT_SELECT_BIT & SMI_MDIO_OE;
    SMI_MDIO_IN = MGMT_PORT_SELECT_BIT ? EXT_MDIO_IN : INT_MDIO_IN;
  end

  assign READY = ready_r;
  assign SOFT_RESET_BIT = soft_busy;
  assign PHY_RESET_BIT = phy_busy;
  assign PHY_CTL_RESET_BIT = phy_ctl_r;
  assign EEPROM_BUSY_FLAG = ee_busy_r;
  assign POWER_STATE_FIELD = pm_r;

  ////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_gate_req;
    CLK_SRC_SEL == CLK_SEL_OFF;
  endsequence
  a_clk_gate_off: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_gate_req ##1 s_gate_req |=> !INT_MII_CLK_EN && !EXT_MII_CLK_EN)
    else $error("MII clocks not gated");
  a_ready_pin: assert property (@(posedge CLK) disable iff (SYS_RST)
    pin_low |=> !READY)
    else $error("ready set during pin reset");
  a_pin_phy_rst: assert property (@(posedge CLK) disable iff (SYS_RST)
    pin_low |=> PHY_RST && PLL_RST && EXEMPT_REG_RST)
    else $error("pin reset not applied");
  a_soft_scope: assert property (@(posedge CLK) disable iff (SYS_RST)
    soft_busy && !full_rst && !phy_busy && !phy_ctl_busy |=> MAC_RST && !PLL_RST && !PHY_RST)
    else $error("soft reset scope wrong");
  a_phy_only: assert property (@(posedge CLK) disable iff (SYS_RST)
    PHY_RESET_WR && !full_rst && !soft_busy |=> PHY_RST && !MAC_RST)
    else $error("PHY reset scope wrong");
  a_mux_rx_path: assert property (@(posedge CLK) disable iff (SYS_RST)
    MII_PORT_SELECT_BIT |-> MAC_RXD == EXT_RXD && MAC_CRS == EXT_CRS)
    else $error("MII mux wrong");
  a_smi_route: assert property (@(posedge CLK) disable iff (SYS_RST)
    !MGMT_PORT_SELECT_BIT |-> SMI_MDIO_IN == INT_MDIO_IN && !EXT_MDIO_OE)
    else $error("SMI route wrong");
  a_wake_normal: assert property (@(posedge CLK) disable iff (SYS_RST)
    WAKE_TEST_WR && state_r == ST_RUN && !SOFT_RESET_WR && !pin_low
      |=> POWER_STATE_FIELD == PM_NORMAL && !READY)
    else $error("wake not handled");
  a_soft_ee_busy: assert property (@(posedge CLK) disable iff (SYS_RST)
    soft_done |=> ##1 EEPROM_BUSY_FLAG)
    else $error("EEPROM busy not shown");
endmodule : reset_and_mii_port_select

// file: testbench/mii_phy_model.sv
// stand-in for an MII PHY: receive and management lines toward the block
`timescale 1ns/100ps
module mii_phy_model #(
  parameter logic [7:0] SEED = 8'h5A
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // lines toward the block
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic col,
  output logic mdio
);
  logic [7:0] lfsr_r;
  ////////////////////////////////////////
  // pattern moves every cycle, so a stale or wrong route cannot match by luck
  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_r <= SEED;
    end else begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    end
  end
  assign rxd = lfsr_r[3:0];
  assign {rx_dv, rx_er, crs, col} = lfsr_r[7:4];
  assign mdio = ^lfsr_r;
endmodule : mii_phy_model

// file: testbench/test_reset_and_mii_port_select.sv
// self-checking bench for reset sequencing and MII port switching
`timescale 1ns/100ps
module test_reset_and_mii_port_select
  import rst_mii_pkg::*;
;
  localparam int POR_N = 20;
  localparam int WAKE_N = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pin_n = 1'b1;
  logic soft_wr = 1'b0, phy_wr = 1'b0, ctl_wr = 1'b0, wake_wr = 1'b0, ee_done = 1'b0;
  logic mii_sel = 1'b0, mgmt_sel = 1'b0, mac_tx_en = 1'b0;
  logic smi_mdc = 1'b0, smi_out = 1'b0, smi_oe = 1'b0;
  logic [1:0] src_sel = CLK_SEL_INT;
  logic [3:0] mac_txd = 4'h0;
  logic ready, soft_bit, phy_bit, ctl_bit, ee_busy, pll_rst, hb_rst, ex_rst, mii_rst;
  logic mac_rst, phy_rst, strap, reload, int_en, ext_en, rx_dv, rx_er, crs, col, smi_in;
  logic [1:0] pstate;
  logic [3:0] rxd, int_txd, ext_txd, int_rxd, ext_rxd;
  logic int_tx_en, int_dv, int_er, int_crs, int_col, int_mdi, int_mdc, int_mdo, int_oe;
  logic ext_tx_en, ext_dv, ext_er, ext_crs, ext_col, ext_mdi, ext_mdc, ext_mdo, ext_oe;
  int mismatches = 0, comparisons = 0, strap_cnt = 0, reload_cnt = 0, n, s0, r0;

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (strap === 1'b1) strap_cnt++;
    if (reload === 1'b1) reload_cnt++;
  end

  reset_and_mii_port_select #(
    .POR_COUNT(POR_N), .WAKE_COUNT(WAKE_N), .PROBE_COUNT(EEPROM_PROBE_CYC)
  ) reset_and_mii_port_select_i (
    .CLK(clk), .SYS_RST(rst), .HW_RESET_PIN_N(pin_n),
    .SOFT_RESET_WR(soft_wr), .PHY_RESET_WR(phy_wr), .PHY_CTL_RESET_WR(ctl_wr),
    .WAKE_TEST_WR(wake_wr), .EEPROM_DONE(ee_done),
    .MII_PORT_SELECT_BIT(mii_sel), .MGMT_PORT_SELECT_BIT(mgmt_sel), .CLK_SRC_SEL(src_sel),
    .READY(ready), .SOFT_RESET_BIT(soft_bit), .PHY_RESET_BIT(phy_bit),
    .PHY_CTL_RESET_BIT(ctl_bit), .EEPROM_BUSY_FLAG(ee_busy), .POWER_STATE_FIELD(pstate),
    .PLL_RST(pll_rst), .HOST_BUS_RST(hb_rst), .EXEMPT_REG_RST(ex_rst), .MII_RST(mii_rst),
    .MAC_RST(mac_rst), .PHY_RST(phy_rst), .STRAP_LATCH(strap), .MAC_ADDR_RELOAD(reload),
    .INT_MII_CLK_EN(int_en), .EXT_MII_CLK_EN(ext_en),
    .MAC_TXD(mac_txd), .MAC_TX_EN(mac_tx_en), .MAC_RXD(rxd), .MAC_RX_DV(rx_dv),
    .MAC_RX_ER(rx_er), .MAC_CRS(crs), .MAC_COL(col),
    .INT_TXD(int_txd), .INT_TX_EN(int_tx_en), .INT_RXD(int_rxd), .INT_RX_DV(int_dv),
    .INT_RX_ER(int_er), .INT_CRS(int_crs), .INT_COL(int_col), .INT_MDIO_IN(int_mdi),
    .INT_MDC(int_mdc), .INT_MDIO_OUT(int_mdo), .INT_MDIO_OE(int_oe),
    .EXT_TXD(ext_txd), .EXT_TX_EN(ext_tx_en), .EXT_RXD(ext_rxd), .EXT_RX_DV(ext_dv),
    .EXT_RX_ER(ext_er), .EXT_CRS(ext_crs), .EXT_COL(ext_col), .EXT_MDIO_IN(ext_mdi),
    .EXT_MDC(ext_mdc), .EXT_MDIO_OUT(ext_mdo), .EXT_MDIO_OE(ext_oe),
    .SMI_MDC(smi_mdc), .SMI_MDIO_OUT(smi_out), .SMI_MDIO_OE(smi_oe), .SMI_MDIO_IN(smi_in)
  );
  mii_phy_model #(.SEED(8'h5A)) int_phy_i (.clk(clk), .rst(rst), .rxd(int_rxd),
    .rx_dv(int_dv), .rx_er(int_er), .crs(int_crs), .col(int_col), .mdio(int_mdi));
  mii_phy_model #(.SEED(8'hC3)) ext_phy_i (.clk(clk), .rst(rst), .rxd(ext_rxd),
    .rx_dv(ext_dv), .rx_er(ext_er), .crs(ext_crs), .col(ext_col), .mdio(ext_mdi));

  ////////////////////////////////////////
  function automatic logic [3:0] pick(input logic s, input logic [3:0] a, input logic [3:0] b);
    return s ? b : a;
  endfunction : pick
  function automatic logic [3:0] en_exp(input logic [1:0] src);
    return {2'h0, src == CLK_SEL_INT, src == CLK_SEL_EXT};
  endfunction : en_exp
  task automatic tick(input int cycles = 1);
    repeat (cycles) @(posedge clk);
    #1;
  endtask : tick
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit
  task automatic check_bus(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bus
  task automatic strobe(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask : strobe
  // bounded poll, as the host would do
  task automatic wait_ready(input int lim);
    n = 0;
    while (ready !== 1'b1 && n < lim) begin
      n++;
      tick();
    end
    check_bit(ready, 1'b1);
  endtask : wait_ready
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////
  initial begin
    #(60000 * 5);
    mismatches++;
    summarize();
  end

  initial begin
    void'($urandom(54));
    tick(5);
    check_bus({ready, pll_rst, phy_rst, ee_busy}, 4'h7);
    rst = 1'b0;
    tick(POR_N - 2);
    check_bus({ready, pll_rst, mac_rst, ex_rst}, 4'h7);
    wait_ready(20);
    check_bus({pll_rst, hb_rst, mac_rst, phy_rst}, 4'h0);
    // pin reset
    s0 = strap_cnt;
    r0 = reload_cnt;
    pin_n = 1'b0;
    tick(5);
    check_bus({ready, pll_rst, ex_rst, phy_rst}, 4'h7);
    pin_n = 1'b1;
    wait_ready(100);
    tick(2);
    check_bit(strap_cnt > s0 && reload_cnt > r0, 1'b1);
    // soft reset: exempt, PLL and PHY domains untouched, no strap relatch
    s0 = strap_cnt;
    r0 = reload_cnt;
    strobe(soft_wr);
    n = 0;
    while (soft_bit === 1'b1 && n < 1000) begin
      if (n == 2) begin
        check_bus({hb_rst, mii_rst, mac_rst, ee_busy}, 4'hF);
        check_bus({pll_rst, phy_rst, ex_rst, ready}, 4'h0);
      end
      n++;
      tick();
    end
    check_bit(n >= SOFT_RST_CYC - 1 && n <= SOFT_RST_CYC + 1, 1'b1);
    wait_ready(10);
    tick(2);
    check_bit(reload_cnt > r0 && strap_cnt == s0, 1'b1);
    strobe(ee_done);
    tick();
    check_bit(ee_busy, 1'b0);
    // PHY-only reset from the power control bit
    strobe(phy_wr);
    n = 0;
    while (phy_bit === 1'b1 && n < 25000) begin
      if (n == 2) check_bus({phy_rst, mac_rst, mii_rst, hb_rst}, 4'h8);
      n++;
      tick();
    end
    check_bit(n >= PHY_RST_CYC - 1 && n <= PHY_RST_CYC + 1, 1'b1);
    // PHY-only reset from the PHY control bit
    // bit stands for one cycle only, as the write starts no PHY timer, so look in the cycle after the write
    strobe(ctl_wr);
    check_bus({ctl_bit, phy_rst, mac_rst, pll_rst}, 4'hC);
    n = 0;
    while (ctl_bit === 1'b1 && n < 25000) begin
      n++;
      tick();
    end
    tick(2);
    check_bus({ctl_bit, phy_rst, ready, 1'b0}, 4'h2);
    // wake write
    strobe(wake_wr);
    wait_ready(WAKE_N + 5);
    check_bus({2'h0, pstate}, {2'h0, PM_NORMAL});
    // switching as the host must do it, random target ports
    for (int i = 0; i < 8; i++) begin
      mac_tx_en = 1'b0;
      src_sel = (i == 3) ? 2'h3 : CLK_SEL_OFF;
      tick(6);
      check_bus({2'h0, int_en, ext_en}, 4'h0);
      // first two passes force both ports on each select
      mii_sel = (i < 2) ? 1'(i) : 1'($urandom);
      mgmt_sel = (i < 2) ? 1'(1 - i) : 1'($urandom);
      tick();
      src_sel = mii_sel ? CLK_SEL_EXT : CLK_SEL_INT;
      tick(6);
      check_bus({2'h0, int_en, ext_en}, en_exp(src_sel));
      repeat (4) begin
        {mac_txd, mac_tx_en, smi_mdc, smi_out, smi_oe} = 8'($urandom);
        #1;
        check_bus(mii_sel ? ext_txd : int_txd, mac_txd);
        check_bit(mii_sel ? ext_tx_en : int_tx_en, mac_tx_en);
        check_bit(mii_sel ? int_tx_en : ext_tx_en, 1'b0);
        check_bus({mgmt_sel ? int_mdc : ext_mdc, mgmt_sel ? int_oe : ext_oe, 2'h0}, 4'h0);
        check_bus(rxd, pick(mii_sel, int_rxd, ext_rxd));
        check_bus({rx_dv, rx_er, crs, col}, pick(mii_sel, {int_dv, int_er, int_crs, int_col},
          {ext_dv, ext_er, ext_crs, ext_col}));
        check_bus(pick(mgmt_sel, {int_mdc, int_mdo, int_oe, smi_in},
          {ext_mdc, ext_mdo, ext_oe, smi_in}),
          {smi_mdc, smi_out, smi_oe, mgmt_sel ? ext_mdi : int_mdi});
        tick();
      end
    end
    summarize();
  end
endmodule : test_reset_and_mii_port_select
